/* bench/quad_wiper_setting_bank_tb_top.sv */
`timescale 1ns/1ps
`include "qw_consts.svh"

module quad_wiper_setting_bank_tb_top
   import qw_pkg::*;
;
   logic        clk_sys;
   logic        rst_n;
   logic [3:0]  straps;
   wire  logic  scl;
   wire  logic  pull;
   wire  logic  sda;
   logic        sda_o;
   logic        sda_oe;
   logic [63:0] taps [0:3];
   logic        incdec;
   int          failures;
   int          num_checks;

   // Open-drain wire with pull-up
   assign sda = (pull | sda_oe) ? 1'b0 : 1'b1;

   qw_setting_bank i_dut
   (
      .i_clk_sys         (clk_sys),
      .i_rst_n           (rst_n),
      .i_scl             (scl),
      .i_sda             (sda),
      .o_sda_o           (sda_o),
      .o_sda_oe          (sda_oe),
      .i_slave_id_straps (straps),
      .o_tap_0           (taps[0]),
      .o_tap_1           (taps[1]),
      .o_tap_2           (taps[2]),
      .o_tap_3           (taps[3]),
      .o_incdec_mode     (incdec)
   );

   qw_host_model i_host
   (
      .i_clk      (clk_sys),
      .i_sda      (sda),
      .o_scl      (scl),
      .o_sda_pull (pull)
   );

   initial
   begin
      clk_sys = 1'b0;
   end

   always #25 clk_sys = ~clk_sys;

   // ----
   // Helpers
   // ----
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h",
                  $time, got, exp);
      end
   endtask : check

   // Data output may only ever pull low
   always @(negedge clk_sys)
      if (sda_oe === 1'b1)
         check(sda_o, `QW_SDA_LOW);

   task automatic send(input logic [7:0] b, input logic ack_exp);
      logic [7:0] q;
      logic       s;
      i_host.xfer_byte(b, 1'b1, q, s);
      check(s, !ack_exp);
   endtask : send

   // Address with write flag, then the instruction byte
   task automatic open_cmd(input logic [3:0] op, input logic [1:0] pot,
                           input logic [1:0] sel);
      i_host.start_cond();
      send({`QW_SLV_FIXED, straps, 1'b0}, 1'b1);
      send({op, pot, sel}, 1'b1);
   endtask : open_cmd

   task automatic act(input logic [3:0] op, input logic [1:0] pot,
                      input logic [1:0] sel);
      open_cmd(op, pot, sel);
      i_host.stop_cond();
      repeat (4) @(posedge clk_sys);
   endtask : act

   task automatic wr(input logic [3:0] op, input logic [1:0] pot,
                     input logic [1:0] sel, input logic [7:0] d);
      open_cmd(op, pot, sel);
      send(d, 1'b1);
      i_host.stop_cond();
      repeat (4) @(posedge clk_sys);
   endtask : wr

   task automatic rd(input logic [3:0] op, input logic [1:0] pot,
                     input logic [1:0] sel, input logic [5:0] exp);
      logic [7:0] q;
      logic       s;
      open_cmd(op, pot, sel);
      i_host.start_cond();
      send({`QW_SLV_FIXED, straps, 1'b1}, 1'b1);
      // First byte acknowledged, so the same register comes again
      i_host.xfer_byte(8'hFF, 1'b0, q, s);
      check(q, {`QW_PAD, exp});
      i_host.xfer_byte(8'hFF, 1'b1, q, s);
      check(q, {`QW_PAD, exp});
      i_host.stop_cond();
   endtask : rd

   task automatic chk_wiper(input logic [1:0] pot, input logic [5:0] v);
      check(taps[pot], `QW_TAP_RST << v);
      rd(`QW_OP_RD_WPR, pot, 2'h0, v);
   endtask : chk_wiper

   // ----
   // Scenarios
   // ----
   task automatic t_recall();
      for (int p = 0; p < 4; p++)
         check(taps[p], `QW_TAP_RST << `QW_SSR_RST);
      check(incdec, 1'b0);
      for (int s = 0; s < 4; s++)
         rd(`QW_OP_RD_SSR, 2'h1, s[1:0], `QW_SSR_RST);
   endtask : t_recall

   // Both array ends and mid values; upper data bits must be ignored
   task automatic t_wiper();
      logic [5:0] v [0:3];
      v = '{6'h00, 6'h3F, 6'h15, 6'h2A};
      for (int p = 0; p < 4; p++)
         wr(`QW_OP_WR_WPR, p[1:0], 2'h0, {2'h3, v[p]});
      for (int p = 0; p < 4; p++)
         chk_wiper(p[1:0], v[p]);
   endtask : t_wiper

   task automatic t_slots();
      for (int s = 0; s < 4; s++)
         wr(`QW_OP_WR_SSR, 2'h2, s[1:0], {2'h0, s[1:0], 4'h7});
      for (int s = 0; s < 4; s++)
         rd(`QW_OP_RD_SSR, 2'h2, s[1:0], {s[1:0], 4'h7});
      // Unknown opcode must be refused
      i_host.start_cond();
      send({`QW_SLV_FIXED, straps, 1'b0}, 1'b1);
      send(8'h34, 1'b0);
      i_host.stop_cond();
      act(`QW_OP_LOAD, 2'h2, 2'h3);
      chk_wiper(2'h2, 6'h37);
      wr(`QW_OP_WR_WPR, 2'h2, 2'h0, 8'h0C);
      act(`QW_OP_SAVE, 2'h2, 2'h1);
      rd(`QW_OP_RD_SSR, 2'h2, 2'h1, 6'h0C);
      rd(`QW_OP_RD_SSR, 2'h3, 2'h1, `QW_SSR_RST);
   endtask : t_slots

   // Step past both ends; the wiper must stick, not wrap
   task automatic t_step();
      wr(`QW_OP_WR_WPR, 2'h3, 2'h0, 8'h3E);
      open_cmd(`QW_OP_STEP, 2'h3, 2'h0);
      check(incdec, 1'b1);
      repeat (3) send(8'h01, 1'b1);
      i_host.stop_cond();
      repeat (4) @(posedge clk_sys);
      chk_wiper(2'h3, `QW_WPR_MAX);
      check(incdec, 1'b0);
      wr(`QW_OP_WR_WPR, 2'h3, 2'h0, 8'h01);
      open_cmd(`QW_OP_STEP, 2'h3, 2'h0);
      repeat (3) send(8'hFE, 1'b1);
      i_host.stop_cond();
      repeat (4) @(posedge clk_sys);
      chk_wiper(2'h3, `QW_WPR_RST);
   endtask : t_step

   // Bit-reversed strap address must be refused, the true one taken
   task automatic t_addr();
      logic [3:0] bad;
      for (int s = 0; s < 16; s++)
      begin
         @(posedge clk_sys);
         straps <= s[3:0];
         bad = {s[0], s[1], s[2], s[3]};
         repeat (4) @(posedge clk_sys);
         if (bad != s[3:0])
         begin
            i_host.start_cond();
            send({`QW_SLV_FIXED, bad, 1'b0}, 1'b0);
            i_host.stop_cond();
         end
         wr(`QW_OP_WR_WPR, 2'h0, 2'h0, {2'h0, s[3:0], 2'h2});
         check(taps[0], `QW_TAP_RST << {s[3:0], 2'h2});
      end
   endtask : t_addr

   task automatic summarize();
      $display("Checks: %0d, failures: %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize

   // Hang guard: a run this long means the bus locked up
   initial
   begin
      #3ms;
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 0, 1);
      summarize();
   end

   initial
   begin
      failures   = 0;
      num_checks = 0;
      rst_n      = 1'b0;
      straps     = 4'h3;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      t_recall();
      t_wiper();
      t_slots();
      t_step();
      t_addr();
      summarize();
   end
endmodule : quad_wiper_setting_bank_tb_top

/* bench/qw_host_model.sv */
`timescale 1ns/1ps

// ----
// Two-wire bus host, one bit per 400 ns
// ----
module qw_host_model
(
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_pull
);
   // Idle bus: clock stands high, data left to its pull-up
   initial
   begin
      o_scl      <= 1'b1;
      o_sda_pull <= 1'b0;
   end

   // Start or repeated start; data is released while clock is low, then falls while clock is high
   task automatic start_cond();
      repeat (3) @(posedge i_clk);
      o_sda_pull <= 1'b0;
      repeat (2) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (2) @(posedge i_clk);
      o_sda_pull <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_scl <= 1'b0;
   endtask : start_cond

   // Stop, then the line is released to idle
   task automatic stop_cond();
      repeat (3) @(posedge i_clk);
      o_sda_pull <= 1'b1;
      repeat (2) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_sda_pull <= 1'b0;
   endtask : stop_cond

   // Eight clocks a bit; low phase is longer so a late release lands first
   task automatic bit_xfer(input logic b, output logic s);
      repeat (3) @(posedge i_clk);
      o_sda_pull <= ~b;
      repeat (2) @(posedge i_clk);
      o_scl <= 1'b1;
      repeat (3) @(posedge i_clk);
      s = i_sda;
      o_scl <= 1'b0;
   endtask : bit_xfer

   // Eight bits MSB first, then the ninth (acknowledge) bit
   task automatic xfer_byte(input  logic [7:0] d,
                            input  logic       ackb,
                            output logic [7:0] q,
                            output logic       s9);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(d[i], s);
         q[i] = s;
      end
      bit_xfer(ackb, s9);
   endtask : xfer_byte
endmodule : qw_host_model

/* common/qw_consts.svh */
`ifndef QW_CONSTS_SVH
`define QW_CONSTS_SVH

// ----------------------------------------------------------------------
// Slave address layout
// ----------------------------------------------------------------------
`define QW_SLV_FIXED   3'h5
`define QW_SLV_FIX_F   7:5
`define QW_SLV_STRAP_F 4:1
`define QW_SLV_RW_BIT  0

// ----------------------------------------------------------------------
// Instruction byte layout and opcodes
// ----------------------------------------------------------------------
`define QW_OP_F        7:4
`define QW_POT_F       3:2
`define QW_SEL_F       1:0
`define QW_OP_RD_WPR   4'h9
`define QW_OP_WR_WPR   4'hA
`define QW_OP_RD_SSR   4'hB
`define QW_OP_WR_SSR   4'hC
`define QW_OP_LOAD     4'hD
`define QW_OP_SAVE     4'hE
`define QW_OP_STEP     4'h2

// ----------------------------------------------------------------------
// Data byte layout and reset values
// ----------------------------------------------------------------------
`define QW_VAL_F       5:0
`define QW_DIR_BIT     0
`define QW_PAD         2'h0
`define QW_WPR_RST     6'h00
`define QW_WPR_MAX     6'h3F
`define QW_SSR_RST     6'h20
`define QW_SLOT_FIRST  2'h0
`define QW_STEP_ONE    6'h01
`define QW_BIT_LAST    3'h7
`define QW_BIT_ONE     3'h1
`define QW_IDX_ADDR    2'h0
`define QW_IDX_INSTR   2'h1
`define QW_IDX_DATA    2'h2
`define QW_IDX_ONE     2'h1
`define QW_TAP_RST     64'h0000_0000_0000_0001
`define QW_SDA_LOW     1'b0

`endif

/* common/qw_pkg.sv */
package qw_pkg;

   // Serial engine states, Gray coded along the usual path
   typedef enum logic [2:0]
   {
      QW_IDLE = 3'h0,
      QW_RX   = 3'h1,
      QW_ACK  = 3'h3,
      QW_TX   = 3'h2,
      QW_RACK = 3'h6
   } qw_state_t;

endpackage : qw_pkg

/* rtl/qw_setting_bank.sv */
`timescale 1ns/1ps
`include "qw_consts.svh"

// What this block does
// - Each of four pots has its own 6-bit wiper register choosing 64 taps.
// - Each wiper has four 6-bit stored settings, all reset to 6'h20.
// - At power-up stored setting 0 of each pot is copied to its wiper.
// - Exactly one tap per pot is connected, chosen by the wiper value only.
// - Selectable taps cover every element junction and both array ends.
// - Four straps form the slave address, first strap least significant.
// - Device answers only when the sent address matches its straps.
// - Host may read and write wiper and stored-setting registers.
// - Instructions move values between a wiper and its own stored settings.
// - An instruction selects increment/decrement mode stepping the wiper.
// - Serial data line is driven only as open drain.
// - Host supplies serial clock; transfers follow its edges as sampled on the system clock.

module qw_setting_bank
   import qw_pkg::*;
#(
   parameter int NPOT = 4,
   parameter int NSSR = 4,
   parameter int WPOS = 6
)
(
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_scl,
   input  wire logic                 i_sda,
   output logic                      o_sda_o,
   output logic                      o_sda_oe,
   input  wire logic [3:0]           i_slave_id_straps,
   output logic      [(1<<WPOS)-1:0] o_tap_0,
   output logic      [(1<<WPOS)-1:0] o_tap_1,
   output logic      [(1<<WPOS)-1:0] o_tap_2,
   output logic      [(1<<WPOS)-1:0] o_tap_3,
   output logic                      o_incdec_mode
);

   localparam int NTAP = 1 << WPOS;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic       scl_s1_r, scl_s2_r, scl_s3_r;
   logic       sda_s1_r, sda_s2_r, sda_s3_r;
   logic [3:0] strap_s1_r, strap_s2_r;

   // Two flops per pin; the third only feeds edge detection
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         scl_s1_r   <= 1'b1;
         scl_s2_r   <= 1'b1;
         scl_s3_r   <= 1'b1;
         sda_s1_r   <= 1'b1;
         sda_s2_r   <= 1'b1;
         sda_s3_r   <= 1'b1;
         strap_s1_r <= 4'h0;
         strap_s2_r <= 4'h0;
      end
      else
      begin
         scl_s1_r   <= i_scl;
         scl_s2_r   <= scl_s1_r;
         scl_s3_r   <= scl_s2_r;
         sda_s1_r   <= i_sda;
         sda_s2_r   <= sda_s1_r;
         sda_s3_r   <= sda_s2_r;
         strap_s1_r <= i_slave_id_straps;
         strap_s2_r <= strap_s1_r;
      end
   end

   // Bus events; all transfer timing derives from host clock edges
   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s2_r & ~scl_s3_r;
   assign scl_fall  = ~scl_s2_r & scl_s3_r;
   assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
   assign bus_stop  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

   // ----------------------------------------------------------------------
   // Serial engine state
   // ----------------------------------------------------------------------
   qw_state_t  state_r;
   logic [2:0] bit_r;
   logic [1:0] idx_r;
   logic [7:0] rx_sh_r;
   logic [7:0] tx_sh_r;
   logic       got_r;
   logic       ack_ok_r;
   logic       rw_r;
   logic       more_r;
   logic [3:0] op_r;
   logic [1:0] pot_r;
   logic [1:0] sel_r;

   logic [7:0] full;
   logic       done, instr_done, data_done, addr_match, op_valid;
   logic [5:0] rd_val;

   // Registers
   logic [WPOS-1:0] wiper_r [NPOT];
   logic [WPOS-1:0] ssr_r   [NPOT][NSSR];
   logic            recall_r;

   // Byte just completed on the eighth rising clock edge
   assign full = {rx_sh_r[6:0], sda_s2_r};
   assign done = (state_r == QW_RX) && scl_rise && (bit_r == `QW_BIT_LAST);
   assign instr_done = done && (idx_r == `QW_IDX_INSTR);
   assign data_done  = done && (idx_r == `QW_IDX_DATA);

   // Fixed upper bits plus straps, strap 0 in the lowest address bit
   assign addr_match = (full[`QW_SLV_FIX_F] == `QW_SLV_FIXED) &&
                       (full[`QW_SLV_STRAP_F] == strap_s2_r);

   assign op_valid = (full[`QW_OP_F] == `QW_OP_RD_WPR) ||
                     (full[`QW_OP_F] == `QW_OP_WR_WPR) ||
                     (full[`QW_OP_F] == `QW_OP_RD_SSR) ||
                     (full[`QW_OP_F] == `QW_OP_WR_SSR) ||
                     (full[`QW_OP_F] == `QW_OP_LOAD)   ||
                     (full[`QW_OP_F] == `QW_OP_SAVE)   ||
                     (full[`QW_OP_F] == `QW_OP_STEP);

   // Read data follows the last accepted instruction; slot for QW_OP_RD_SSR, wiper otherwise
   assign rd_val = (op_r == `QW_OP_RD_SSR) ? ssr_r[pot_r][sel_r]
                                           : wiper_r[pot_r];

   // Protocol sequencing; stop and start override any state
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r <= QW_IDLE;
         bit_r   <= 3'h0;
         idx_r   <= `QW_IDX_ADDR;
         got_r   <= 1'b0;
         more_r  <= 1'b0;
         tx_sh_r <= 8'h00;
      end
      else if (bus_stop)
         state_r <= QW_IDLE;
      else if (bus_start)
      begin
         state_r <= QW_RX;
         bit_r   <= 3'h0;
         idx_r   <= `QW_IDX_ADDR;
         got_r   <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            QW_IDLE: ;
            QW_RX:
            begin
               if (scl_rise)
               begin
                  bit_r <= bit_r + `QW_BIT_ONE;
                  got_r <= done;
               end
               else if (scl_fall && got_r)
               begin
                  got_r   <= 1'b0;
                  state_r <= ack_ok_r ? QW_ACK : QW_IDLE;
                  if (idx_r != `QW_IDX_DATA)
                     idx_r <= idx_r + `QW_IDX_ONE;
               end
            end
            QW_ACK:
            begin
               if (scl_fall)
               begin
                  if (rw_r && (idx_r == `QW_IDX_INSTR))
                  begin
                     state_r <= QW_TX;
                     tx_sh_r <= {`QW_PAD, rd_val};
                  end
                  else
                     state_r <= QW_RX;
               end
            end
            QW_TX:
            begin
               if (scl_fall)
               begin
                  bit_r   <= bit_r + `QW_BIT_ONE;
                  tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                  if (bit_r == `QW_BIT_LAST)
                     state_r <= QW_RACK;
               end
            end
            QW_RACK:
            begin
               if (scl_rise)
                  more_r <= ~sda_s2_r;
               else if (scl_fall)
               begin
                  // Host acknowledged: repeat the same register
                  state_r <= more_r ? QW_TX : QW_IDLE;
                  tx_sh_r <= {`QW_PAD, rd_val};
               end
            end
            default: state_r <= QW_IDLE;
         endcase
      end
   end

   // Shift-in and per-byte decode
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_sh_r  <= 8'h00;
         ack_ok_r <= 1'b0;
         rw_r     <= 1'b0;
      end
      else if ((state_r == QW_RX) && scl_rise)
      begin
         rx_sh_r <= full;
         if (done && (idx_r == `QW_IDX_ADDR))
         begin
            ack_ok_r <= addr_match;
            rw_r     <= full[`QW_SLV_RW_BIT];
         end
         else if (instr_done)
            ack_ok_r <= op_valid;
         else if (data_done)
            ack_ok_r <= 1'b1;
      end
   end

   // Instruction latch and increment/decrement mode flag
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         op_r          <= `QW_OP_RD_WPR;
         pot_r         <= 2'h0;
         sel_r         <= 2'h0;
         o_incdec_mode <= 1'b0;
      end
      else if (instr_done && op_valid)
      begin
         op_r          <= full[`QW_OP_F];
         pot_r         <= full[`QW_POT_F];
         sel_r         <= full[`QW_SEL_F];
         o_incdec_mode <= (full[`QW_OP_F] == `QW_OP_STEP);
      end
   end

   // Open drain: line only pulled low, registered to avoid glitches
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_sda_oe <= 1'b0;
      else
         o_sda_oe <= (state_r == QW_ACK) ||
                     ((state_r == QW_TX) && !tx_sh_r[7]);
   end
   assign o_sda_o = `QW_SDA_LOW;

   // ----------------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------------
   logic           do_load, do_save, do_wr_w, do_wr_s, do_step;
   logic [WPOS-1:0] step_up, step_dn;

   assign do_load = instr_done && (full[`QW_OP_F] == `QW_OP_LOAD);
   assign do_save = instr_done && (full[`QW_OP_F] == `QW_OP_SAVE);
   assign do_wr_w = data_done && (op_r == `QW_OP_WR_WPR);
   assign do_wr_s = data_done && (op_r == `QW_OP_WR_SSR);
   assign do_step = data_done && (op_r == `QW_OP_STEP);

   // Saturating steps so a long burst cannot wrap end to end
   assign step_up = (wiper_r[pot_r] == `QW_WPR_MAX) ? `QW_WPR_MAX
                    : wiper_r[pot_r] + `QW_STEP_ONE;
   assign step_dn = (wiper_r[pot_r] == `QW_WPR_RST) ? `QW_WPR_RST
                    : wiper_r[pot_r] - `QW_STEP_ONE;

   // One-shot recall strobe in the first cycle after reset release
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         recall_r <= 1'b1;
      else
         recall_r <= 1'b0;
   end

   // Wiper registers, one per pot
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int p = 0; p < NPOT; p++)
            wiper_r[p] <= `QW_WPR_RST;
      end
      else if (recall_r)
      begin
         for (int p = 0; p < NPOT; p++)
            wiper_r[p] <= ssr_r[p][`QW_SLOT_FIRST];
      end
      else if (do_load)
         wiper_r[full[`QW_POT_F]] <= ssr_r[full[`QW_POT_F]][full[`QW_SEL_F]];
      else if (do_wr_w)
         wiper_r[pot_r] <= full[`QW_VAL_F];
      else if (do_step)
         wiper_r[pot_r] <= full[`QW_DIR_BIT] ? step_up : step_dn;
   end

   // Stored settings; image restored to a fixed value on reset
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int p = 0; p < NPOT; p++)
            for (int s = 0; s < NSSR; s++)
               ssr_r[p][s] <= `QW_SSR_RST;
      end
      else if (do_save)
         ssr_r[full[`QW_POT_F]][full[`QW_SEL_F]] <=
            wiper_r[full[`QW_POT_F]];
      else if (do_wr_s)
         ssr_r[pot_r][sel_r] <= full[`QW_VAL_F];
   end

   // ----------------------------------------------------------------------
   // Tap decoders
   // ----------------------------------------------------------------------
   logic [NTAP-1:0] tap_w [NPOT];

   for (genvar g = 0; g < NPOT; g++)
   begin : g_tap
      qw_tap_decode #(.WPOS(WPOS)) u_dec
      (
         .i_clk_sys (i_clk_sys),
         .i_rst_n   (i_rst_n),
         .i_pos     (wiper_r[g]),
         .o_tap     (tap_w[g])
      );
   end

   assign o_tap_0 = tap_w[0];
   assign o_tap_1 = tap_w[1];
   assign o_tap_2 = tap_w[2];
   assign o_tap_3 = tap_w[3];

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_recall_first_slot: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      recall_r |=> (wiper_r[0] == $past(ssr_r[0][0])) &&
                   (wiper_r[3] == $past(ssr_r[3][0])))
      else $error("power-up recall did not copy slot 0");

   chk_addr_mismatch_drop: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state_r == QW_RX) && got_r && scl_fall && !ack_ok_r &&
      (idx_r == `QW_IDX_ADDR) && !bus_start && !bus_stop |=>
      (state_r == QW_IDLE) ##1 !o_sda_oe)
      else $error("answered a foreign slave address");

   chk_strap_lsb_first: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (done && idx_r == `QW_IDX_ADDR && full[1] != strap_s2_r[0]) |=>
      !ack_ok_r)
      else $error("strap 0 not in lowest address bit");

   chk_wiper_write_lands: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      do_wr_w && !recall_r |=> wiper_r[$past(pot_r)] == $past(full[5:0]))
      else $error("wiper write lost");

   chk_save_copies: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      do_save |=> ssr_r[$past(full[3:2])][$past(full[1:0])] ==
                  $past(wiper_r[full[3:2]]))
      else $error("save did not copy wiper into slot");

   chk_step_moves_one: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      do_step && full[0] && wiper_r[pot_r] != `QW_WPR_MAX |=>
      wiper_r[$past(pot_r)] == $past(wiper_r[pot_r]) + `QW_STEP_ONE)
      else $error("increment step wrong");

   chk_step_saturates: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      do_step && !full[0] && wiper_r[pot_r] == `QW_WPR_RST |=>
      wiper_r[$past(pot_r)] == `QW_WPR_RST)
      else $error("decrement wrapped below zero");

   chk_sda_pull_only: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_sda_oe |-> !o_sda_o)
      else $error("data line driven high");

   chk_sda_on_clock: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_sda_oe) |-> $past(scl_fall, 2))
      else $error("data line changed without host clock fall");

endmodule : qw_setting_bank

/* rtl/qw_tap_decode.sv */
`timescale 1ns/1ps
`include "qw_consts.svh"

// ----------------------------------------------------------------------
// Wiper position to one-hot tap switch decoder
// ----------------------------------------------------------------------
module qw_tap_decode
   import qw_pkg::*;
#(
   parameter int WPOS = 6
)
(
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst_n,
   input  wire logic [WPOS-1:0]      i_pos,
   output logic      [(1<<WPOS)-1:0] o_tap
);

   localparam int NTAP = 1 << WPOS;

   // Registered so no two switches ever close together on a glitch
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_tap <= `QW_TAP_RST;
      else
         o_tap <= NTAP'(1) << i_pos;
   end

   chk_tap_single_on: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      $onehot(o_tap))
      else $error("tap switches not one-hot");

   chk_tap_every_edge: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      ##1 o_tap[$past(i_pos)])
      else $error("closed tap does not follow wiper value");

endmodule : qw_tap_decode
